// *** rtl/tsel_source_select.sv ***
// source selection for the time code generator's time and user bits
`timescale 1ns/1ps
module tsel_source_select
  import tsel_pkg::*;
#(
  parameter logic [7:0] XX_BASE = 8'h00,
  // bit position of byte XX for each remote pin, pin 0 in the low field
  parameter logic [17:0] PIN_MAP = {3'h5, 3'h4, 3'h3, 3'h2, 3'h1, 3'h0}
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic frame_tick,
  input wire logic out_is_30,
  input wire logic gen_run,
  input wire logic jam_continuous,
  input wire tsel_pkg::tsel_tc_t jam_offset,
  input wire logic [7:0] jam_window,
  input wire tsel_pkg::tsel_reader_t reader,
  input wire tsel_pkg::tsel_tc_t panel_time,
  input wire logic panel_time_load,
  input wire logic [31:0] panel_ub,
  input wire logic panel_ub_load,
  input wire logic [31:0] date_ub,
  input wire logic [5:0] rctl_pins,
  input wire logic local_time,
  input wire logic daylight_saving,
  input wire logic menu_show,
  input wire tsel_pkg::tsel_mode_t menu_choice,
  input wire logic menu_select,
  output tsel_pkg::tsel_mode_t generator_source_setting,
  output tsel_pkg::tsel_tc_t gen_time,
  output logic [31:0] gen_ub,
  output logic ub_transfer_led,
  output logic jam_led,
  output logic [2:0] bg_flags,
  output logic [7:0] separator,
  output logic choice_blink
);
  tsel_mode_t setting_q, setting_d;
  tsel_tc_t gen_time_q, gen_time_d;
  logic [31:0] gen_ub_q, gen_ub_d;
  logic [31:0] panel_ub_q, panel_ub_d;
  logic ub_led_q, ub_led_d;
  logic jam_led_q, jam_led_d;
  logic [2:0] bg_q, bg_d;
  logic [7:0] sep_q, sep_d;
  logic [4:0] blink_cnt_q, blink_cnt_d;
  logic phase_q, phase_d;
  logic blink_q, blink_d;
  logic [5:0] pins_s;
  logic [7:0] xx_byte;
  tsel_tc_t next_run;
  tsel_tc_t jam_ref;
  tsel_tc_t conv_ref;
  logic [23:0] diff;
  logic reload;

  // the pin byte logic is built for exactly six remote pins
  if (TSEL_RCTL_PINS != 6)
  begin : g_pin_count_check
    $error("remote pin count must be six");
  end
  function automatic tsel_tc_t tc_add(tsel_tc_t a, tsel_tc_t b, logic fps30);
    logic [6:0] f, s, m;
    logic [5:0] h;
    logic [4:0] n;
    tsel_tc_t r;
    n = fps30 ? TSEL_FPS_30 : TSEL_FPS_25;
    f = {2'h0, a.frames} + {2'h0, b.frames};
    r.frames = (f >= {2'h0, n}) ? 5'(f - {2'h0, n}) : f[4:0];
    s = {1'h0, a.seconds} + {1'h0, b.seconds} + {6'h00, f >= {2'h0, n}};
    r.seconds = (s >= {1'h0, TSEL_SIXTY}) ? 6'(s - {1'h0, TSEL_SIXTY}) : s[5:0];
    m = {1'h0, a.minutes} + {1'h0, b.minutes} + {6'h00, s >= {1'h0, TSEL_SIXTY}};
    r.minutes = (m >= {1'h0, TSEL_SIXTY}) ? 6'(m - {1'h0, TSEL_SIXTY}) : m[5:0];
    h = {1'h0, a.hours} + {1'h0, b.hours} + {5'h00, m >= {1'h0, TSEL_SIXTY}};
    r.hours = (h >= {1'h0, TSEL_DAY_HOURS}) ? 5'(h - {1'h0, TSEL_DAY_HOURS}) : h[4:0];
    return r;
  endfunction
  function automatic logic [23:0] tc_frames(tsel_tc_t a, logic fps30);
    logic [23:0] t;
    t = 24'(a.hours) * 24'h00003c + 24'(a.minutes);
    t = t * 24'h00003c + 24'(a.seconds);
    t = t * 24'(fps30 ? TSEL_FPS_30 : TSEL_FPS_25) + 24'(a.frames);
    return t;
  endfunction
  // frame number scaled from the input standard to the output standard
  function automatic tsel_tc_t tc_convert(tsel_tc_t a, logic fps30);
    logic [7:0] f;
    tsel_tc_t r;
    r = a;
    f = fps30 ? (8'(a.frames) * 8'h06) / 8'h05 : (8'(a.frames) * 8'h05) / 8'h06;
    r.frames = f[4:0];
    return r;
  endfunction
  function automatic logic [31:0] tc_pack(tsel_tc_t a);
    return {3'h0, a.hours, 2'h0, a.minutes, 2'h0, a.seconds, 3'h0, a.frames};
  endfunction
  tsel_sync2 #(
    .WIDTH(TSEL_RCTL_PINS)
  ) tsel_sync2_inst (
    .clock(clock),
    .rst(rst),
    .async_in(rctl_pins),
    .sync_out(pins_s)
  );

  always_comb
  begin
    xx_byte = XX_BASE;
    for (int i = 0; i < TSEL_RCTL_PINS; i++)
      xx_byte[PIN_MAP[3*i +: 3]] = pins_s[i];
  end

  always_comb
  begin
    next_run = gen_run ? tc_add(gen_time_q, TSEL_TC_ONE, out_is_30) : gen_time_q;
    jam_ref = tc_add(reader.time_bits, jam_offset, out_is_30);
    // reference in the output frame numbering
    conv_ref = tc_add(tc_convert(reader.time_bits, out_is_30), jam_offset, out_is_30);
    diff = (tc_frames(next_run, out_is_30) > tc_frames(conv_ref, out_is_30))
      ? tc_frames(next_run, out_is_30) - tc_frames(conv_ref, out_is_30)
      : tc_frames(conv_ref, out_is_30) - tc_frames(next_run, out_is_30);
    reload = reader.valid && (diff > 24'(jam_window));
  end

  always_comb
  begin
    setting_d = setting_q;
    gen_time_d = gen_time_q;
    gen_ub_d = gen_ub_q;
    panel_ub_d = panel_ub_q;
    jam_led_d = jam_led_q;
    if (menu_select)
      setting_d = menu_choice;
    // panel entry refused outside panel data mode
    if (panel_ub_load && setting_q == TSEL_MODE_DATA)
      panel_ub_d = panel_ub;
    if (setting_q == TSEL_MODE_CONVERT)
    begin
      if (frame_tick)
      begin
        gen_time_d = next_run;
        jam_led_d = 1'b0;
        if (reload)
        begin
          gen_time_d = conv_ref;
          jam_led_d = 1'b1;
        end
      end
    end
    else
    begin
      jam_led_d = jam_continuous;
      if (panel_time_load && !jam_continuous)
        gen_time_d = panel_time;
      else if (frame_tick)
        gen_time_d = (jam_continuous && reader.valid) ? jam_ref : next_run;
    end
    if (frame_tick)
    begin
      case (setting_q)
        TSEL_MODE_DATA: gen_ub_d = panel_ub_q;
        TSEL_MODE_RTIME: gen_ub_d = tc_pack(reader.time_bits);
        // reader user bits, time follows by jam
        TSEL_MODE_RUB: gen_ub_d = reader.user_bits;
        TSEL_MODE_DATE: gen_ub_d = date_ub;
        TSEL_MODE_CONVERT: gen_ub_d = panel_ub_q;
        // fixed tail under the pin byte
        TSEL_MODE_RCTL: gen_ub_d = {xx_byte, TSEL_RCTL_TAIL};
        default: gen_ub_d = panel_ub_q;
      endcase
    end
  end

  always_comb
  begin
    // transfer indicator only in transfer modes
    ub_led_d = (setting_q == TSEL_MODE_RTIME) || (setting_q == TSEL_MODE_RUB);
    bg_d = (setting_q == TSEL_MODE_RCTL) ? TSEL_BG_RCTL : TSEL_BG_NONE;
    sep_d = (local_time && daylight_saving) ? TSEL_SEP_PERIOD : TSEL_SEP_COLON;
    blink_cnt_d = blink_cnt_q;
    phase_d = phase_q;
    if (frame_tick)
    begin
      blink_cnt_d = (blink_cnt_q == TSEL_BLINK_FRAMES) ? TSEL_BLINK_RESET : 5'(blink_cnt_q + 5'h01);
      phase_d = (blink_cnt_q == TSEL_BLINK_FRAMES) ? !phase_q : phase_q;
    end
    blink_d = menu_show && (menu_choice == setting_q) && phase_q;
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      setting_q <= TSEL_MODE_RESET;
      gen_time_q <= TSEL_TC_ZERO;
      gen_ub_q <= TSEL_UB_RESET;
      panel_ub_q <= TSEL_UB_RESET;
      ub_led_q <= 1'b0;
      jam_led_q <= 1'b0;
      bg_q <= TSEL_BG_NONE;
      sep_q <= TSEL_SEP_COLON;
      blink_cnt_q <= TSEL_BLINK_RESET;
      phase_q <= 1'b0;
      blink_q <= 1'b0;
    end
    else
    begin
      setting_q <= setting_d;
      gen_time_q <= gen_time_d;
      gen_ub_q <= gen_ub_d;
      panel_ub_q <= panel_ub_d;
      ub_led_q <= ub_led_d;
      jam_led_q <= jam_led_d;
      bg_q <= bg_d;
      sep_q <= sep_d;
      blink_cnt_q <= blink_cnt_d;
      phase_q <= phase_d;
      blink_q <= blink_d;
    end
  end

  assign generator_source_setting = setting_q;
  assign gen_time = gen_time_q;
  assign gen_ub = gen_ub_q;
  assign ub_transfer_led = ub_led_q;
  assign jam_led = jam_led_q;
  assign bg_flags = bg_q;
  assign separator = sep_q;
  assign choice_blink = blink_q;

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  a_menu_store: assert property (menu_select |=> setting_q == $past(menu_choice))
    else $error("menu select did not store choice");
  a_ub_led_off: assert property (!(setting_q inside {TSEL_MODE_RTIME, TSEL_MODE_RUB}) [*2] |-> !ub_led_q)
    else $error("transfer led on outside transfer modes");
  a_rtime_copy: assert property (frame_tick && setting_q == TSEL_MODE_RTIME |=>
    gen_ub_q == tc_pack($past(reader.time_bits)) && ub_led_q)
    else $error("reader time not copied to user bits");
  a_rub_copy: assert property (frame_tick && setting_q == TSEL_MODE_RUB |=> gen_ub_q == $past(reader.user_bits))
    else $error("reader user bits not copied");
  a_rctl_tail: assert property (frame_tick && setting_q == TSEL_MODE_RCTL |=> gen_ub_q[23:0] == TSEL_RCTL_TAIL)
    else $error("pin mode user bit tail wrong");
  a_rctl_flags: assert property (setting_q == TSEL_MODE_RCTL && !menu_select |=> bg_q == TSEL_BG_RCTL)
    else $error("pin mode flags not set");
  a_sep_char: assert property (local_time && daylight_saving |=> sep_q == TSEL_SEP_PERIOD)
    else $error("separator not period under daylight saving");
  a_jam_follow: assert property (frame_tick && jam_continuous && reader.valid && !panel_time_load
    && setting_q != TSEL_MODE_CONVERT |=> gen_time_q == tc_add($past(reader.time_bits), $past(jam_offset), $past(out_is_30)))
    else $error("jam did not load reader plus offset");
  a_time_hold: assert property (!frame_tick && !panel_time_load |=> $stable(gen_time_q))
    else $error("generator time moved without cause");
  a_panel_ub: assert property (frame_tick && setting_q == TSEL_MODE_DATA |=> gen_ub_q == $past(panel_ub_q))
    else $error("panel user bits not used");
  a_conv_rate: assert property (frame_tick && setting_q == TSEL_MODE_CONVERT && !reload && gen_run |=>
    gen_time_q == tc_add($past(gen_time_q), TSEL_TC_ONE, $past(out_is_30)))
    else $error("convert mode did not advance one frame");
  a_conv_jam: assert property (frame_tick && setting_q == TSEL_MODE_CONVERT && reload |=> jam_led_q)
    else $error("jam led not lit on reload");

  c_rctl_mode: cover property (frame_tick && setting_q == TSEL_MODE_RCTL);
  c_conv_reload: cover property (frame_tick && setting_q == TSEL_MODE_CONVERT && reload);
  c_rub_jam: cover property (frame_tick && setting_q == TSEL_MODE_RUB && jam_continuous && reader.valid);
  c_blink: cover property (choice_blink ##1 !choice_blink);
endmodule // tsel_source_select

// *** rtl/tsel_pkg.sv ***
// shared types and constants for the time code generator source selection
package tsel_pkg;

  // generator source setting, gray coded along the menu order
  typedef enum logic [2:0] {
    TSEL_MODE_DATA    = 3'h0,
    TSEL_MODE_RTIME   = 3'h1,
    TSEL_MODE_RUB     = 3'h3,
    TSEL_MODE_DATE    = 3'h2,
    TSEL_MODE_CONVERT = 3'h6,
    TSEL_MODE_RCTL    = 3'h7
  } tsel_mode_t;

  // time code in binary fields
  typedef struct packed {
    logic [4:0] hours;
    logic [5:0] minutes;
    logic [5:0] seconds;
    logic [4:0] frames;
  } tsel_tc_t;

  // one reader's decoded output
  typedef struct packed {
    tsel_tc_t time_bits;
    logic [31:0] user_bits;
    logic valid;
  } tsel_reader_t;

  localparam tsel_mode_t TSEL_MODE_RESET = TSEL_MODE_DATA;
  localparam tsel_tc_t TSEL_TC_ZERO = '0;
  localparam tsel_tc_t TSEL_TC_ONE = '{hours: 5'h00, minutes: 6'h00, seconds: 6'h00, frames: 5'h01};
  localparam logic [4:0] TSEL_FPS_30 = 5'h1e;
  localparam logic [4:0] TSEL_FPS_25 = 5'h19;
  localparam logic [5:0] TSEL_SIXTY = 6'h3c;
  localparam logic [4:0] TSEL_DAY_HOURS = 5'h18;
  localparam logic [31:0] TSEL_UB_RESET = 32'h0000_0000;
  // fixed low three bytes of the remote-pin user bits
  localparam logic [23:0] TSEL_RCTL_TAIL = 24'h80_8093;
  localparam logic [2:0] TSEL_BG_NONE = 3'h0;
  // binary group flag pattern for remote-pin mode; value is arbitrary
  localparam logic [2:0] TSEL_BG_RCTL = 3'h5;
  localparam logic [7:0] TSEL_SEP_COLON = 8'h3a;
  localparam logic [7:0] TSEL_SEP_PERIOD = 8'h2e;
  localparam logic [4:0] TSEL_BLINK_FRAMES = 5'h0f;
  localparam logic [4:0] TSEL_BLINK_RESET = 5'h00;
  localparam int TSEL_RCTL_PINS = 6;

endpackage

// *** rtl/tsel_sync2.sv ***
// two flip-flop synchroniser for asynchronous pin levels
`timescale 1ns/1ps
module tsel_sync2 #(
  parameter int WIDTH = 6
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  if (WIDTH < 1)
  begin : g_width_check
    $error("tsel_sync2 width must be positive");
  end

  always_comb
  begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;
endmodule // tsel_sync2

// *** test/tsel_far_model.sv ***
// far-side model: active reader output and remote pin levels
`timescale 1ns/1ps
module tsel_far_model
  import tsel_pkg::*;
(
  input wire logic clock,
  input wire tsel_pkg::tsel_tc_t time_set,
  input wire logic [31:0] ub_set,
  input wire logic valid_set,
  input wire logic [5:0] pins_set,
  output tsel_pkg::tsel_reader_t reader,
  output logic [5:0] rctl_pins
);
  always @(posedge clock)
  begin
    // lost code shows a scrambled time, never the last good value
    reader <= '{time_bits: valid_set ? time_set : ~time_set, user_bits: ub_set, valid: valid_set};
    rctl_pins <= pins_set;
  end
endmodule // tsel_far_model

// *** test/tsel_source_select_tb.sv ***
// self-checking bench for the generator source selection
`timescale 1ns/1ps
module tsel_source_select_tb;
  import tsel_pkg::*;
  logic clock = 0, rst = 1, frame_tick = 0, out_is_30 = 1, gen_run = 0, jam_continuous = 0;
  tsel_tc_t jam_offset = '0, panel_time = '0, tm = '0, gen_time;
  logic [7:0] jam_window = 8'h02, separator;
  logic panel_time_load = 0, panel_ub_load = 0, local_time = 0, daylight_saving = 0;
  logic [31:0] panel_ub = '0, date_ub = '0, ub = '0, rub = '0, exp_ub = '0, gen_ub;
  logic menu_show = 0, menu_select = 0, valid_set = 0, ub_transfer_led, jam_led, choice_blink;
  logic [5:0] pins = '0, rctl_pins;
  logic [2:0] bg_flags;
  tsel_mode_t menu_choice = TSEL_MODE_DATA, generator_source_setting;
  tsel_mode_t md[4] = '{TSEL_MODE_RTIME, TSEL_MODE_RUB, TSEL_MODE_DATE, TSEL_MODE_RCTL};
  tsel_reader_t reader;
  logic [31:0] exp_q[$];
  int err_count = 0, checks_done = 0, hi = 0;

  always #5 clock = ~clock;

  tsel_far_model tsel_far_model_inst (.clock(clock), .time_set(tm), .ub_set(rub), .valid_set(valid_set),
    .pins_set(pins), .reader(reader), .rctl_pins(rctl_pins));

  tsel_source_select tsel_source_select_inst (.clock(clock), .rst(rst), .frame_tick(frame_tick),
    .out_is_30(out_is_30), .gen_run(gen_run), .jam_continuous(jam_continuous), .jam_offset(jam_offset),
    .jam_window(jam_window), .reader(reader), .panel_time(panel_time), .panel_time_load(panel_time_load),
    .panel_ub(panel_ub), .panel_ub_load(panel_ub_load), .date_ub(date_ub), .rctl_pins(rctl_pins),
    .local_time(local_time), .daylight_saving(daylight_saving), .menu_show(menu_show),
    .menu_choice(menu_choice), .menu_select(menu_select), .generator_source_setting(generator_source_setting),
    .gen_time(gen_time), .gen_ub(gen_ub), .ub_transfer_led(ub_transfer_led), .jam_led(jam_led),
    .bg_flags(bg_flags), .separator(separator), .choice_blink(choice_blink));

  task automatic report_and_stop();
    if (err_count == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic chk_t(input tsel_tc_t e);
    chk("gen_time", 32'(e), 32'(gen_time));
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  // each frame result is noted before the tick that produces it
  task automatic frame();
    exp_q.push_back(exp_ub);
    frame_tick = 1;
    cyc(1);
    frame_tick = 0;
    cyc(1);
  endtask

  task automatic sel(input tsel_mode_t m);
    menu_choice = m;
    menu_select = 1;
    cyc(1);
    menu_select = 0;
    cyc(1);
    chk("setting", 32'(m), 32'(generator_source_setting));
  endtask

  always @(posedge clock)
  begin
    if (frame_tick && !rst)
    begin
      @(negedge clock);
      chk("gen_ub", exp_q.pop_front(), gen_ub);
    end
  end

  initial
  begin
    #100us;
    err_count++;
    report_and_stop();
  end

  initial
  begin
    void'($urandom(36));
    ub = $urandom;
    rub = $urandom;
    date_ub = $urandom;
    pins = 6'($urandom);
    cyc(12);
    rst = 0;
    chk("setting", 32'(TSEL_MODE_DATA), 32'(generator_source_setting));
    chk("sep", 32'h3a, 32'(separator));
    chk("leds", 32'h0, {30'h0, ub_transfer_led, jam_led});
    panel_ub = ub;
    panel_ub_load = 1;
    cyc(1);
    panel_ub_load = 0;
    exp_ub = ub;
    frame();
    panel_time = '{5'h01, 6'h02, 6'h03, 5'h0a};
    panel_time_load = 1;
    cyc(1);
    panel_time_load = 0;
    cyc(1);
    chk_t(panel_time);
    gen_run = 1;
    frame();
    gen_run = 0;
    chk_t('{5'h01, 6'h02, 6'h03, 5'h0b});
    tm = '{5'h02, 6'h0a, 6'h14, 5'h04};
    valid_set = 1;
    foreach (md[i])
    begin
      sel(md[i]);
      // load outside panel data mode must be ignored
      panel_ub = ~ub;
      panel_ub_load = 1;
      cyc(1);
      panel_ub_load = 0;
      case (md[i])
        TSEL_MODE_RTIME: exp_ub = {3'h0, tm.hours, 2'h0, tm.minutes, 2'h0, tm.seconds, 3'h0, tm.frames};
        TSEL_MODE_RUB: exp_ub = rub;
        TSEL_MODE_DATE: exp_ub = date_ub;
        default: exp_ub = {2'h0, pins, 24'h808093};
      endcase
      frame();
      chk("xfer_led", 32'(i < 2), 32'(ub_transfer_led));
      chk("bg", (i == 3) ? 32'h5 : 32'h0, 32'(bg_flags));
    end
    sel(TSEL_MODE_RUB);
    jam_continuous = 1;
    panel_time = '0;
    panel_time_load = 1;
    cyc(1);
    panel_time_load = 0;
    cyc(1);
    chk_t('{5'h01, 6'h02, 6'h03, 5'h0b});
    jam_offset = '{5'h00, 6'h00, 6'h00, 5'h05};
    exp_ub = rub;
    frame();
    chk_t('{5'h02, 6'h0a, 6'h14, 5'h09});
    chk("jam_led", 32'h1, 32'(jam_led));
    jam_offset = '0;
    jam_continuous = 0;
    sel(TSEL_MODE_CONVERT);
    gen_run = 1;
    tm.frames = 5'h14;
    cyc(2);
    exp_ub = ub;
    frame();
    chk_t('{5'h02, 6'h0a, 6'h14, 5'h18});
    chk("jam_led", 32'h1, 32'(jam_led));
    tm.frames = 5'h15;
    cyc(2);
    frame();
    chk_t('{5'h02, 6'h0a, 6'h14, 5'h19});
    chk("jam_led", 32'h0, 32'(jam_led));
    out_is_30 = 0;
    tm.frames = 5'h18;
    cyc(2);
    frame();
    chk_t('{5'h02, 6'h0a, 6'h14, 5'h14});
    for (int k = 0; k < 4; k++)
    begin
      {local_time, daylight_saving} = 2'(k);
      cyc(2);
      chk("sep", (k == 3) ? 32'h2e : 32'h3a, 32'(separator));
    end
    menu_show = 1;
    menu_choice = TSEL_MODE_CONVERT;
    repeat (40)
    begin
      frame();
      hi += int'(choice_blink === 1'b1);
    end
    chk("blink_on", 32'h1, 32'(hi > 0 && hi < 40));
    hi = 0;
    menu_choice = TSEL_MODE_DATA;
    repeat (20)
    begin
      frame();
      hi += int'(choice_blink !== 1'b0);
    end
    chk("blink_off", 32'h0, 32'(hi));
    report_and_stop();
  end
endmodule // tsel_source_select_tb
